// [agrc_pkg.sv]
package agrc_pkg;

    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int unsigned AGRC_ADDR_W   = 12;
    localparam int unsigned AGRC_DATA_W   = 32;
    localparam int unsigned AGRC_MAX_CONV = 4;

    localparam logic [11:0] AGRC_OFF_CTRL   = 12'h000;
    localparam logic [11:0] AGRC_OFF_STATUS = 12'h004;
    localparam logic [11:0] AGRC_OFF_MODE   = 12'h008;
    localparam logic [3:0][11:0] AGRC_OFF_CFG = {12'h0DC, 12'h098, 12'h054, 12'h010};

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned AGRC_CONV_REQ_LSB = 0;
    localparam int unsigned AGRC_RST_REQ_LSB  = 16;
    localparam int unsigned AGRC_BUSY_LSB     = 0;
    localparam int unsigned AGRC_SEQ_MODE_LSB = 0;
    localparam int unsigned AGRC_CFG_NUM_LSB  = 24;
    localparam int unsigned AGRC_CFG_MODE_BIT = 27;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] AGRC_CTRL_RST     = 32'h0000_0000;
    localparam logic [3:0]  AGRC_SEQ_MODE_RST = 4'h0;
    localparam logic        AGRC_IN_MODE_RST  = 1'b1;
    localparam logic [2:0]  AGRC_NUM_CH_RST   = 3'h7;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned AGRC_CLK_PERIOD_PS = 4000;
    localparam int unsigned AGRC_RST_PULSE_NS  = 100;
    localparam int unsigned AGRC_RST_WAIT_NS   = 1000;
    localparam int unsigned AGRC_CNT_W         = 16;
    localparam logic [15:0] AGRC_RST_PULSE_CYC =
        16'((AGRC_RST_PULSE_NS * 1000 + AGRC_CLK_PERIOD_PS - 1) / AGRC_CLK_PERIOD_PS);
    localparam logic [15:0] AGRC_RST_WAIT_CYC  =
        16'((AGRC_RST_WAIT_NS * 1000 + AGRC_CLK_PERIOD_PS - 1) / AGRC_CLK_PERIOD_PS);

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {
        AGRC_XFER_CFG,
        AGRC_XFER_CONV
    } agrc_xfer_kind_t;

    typedef struct packed {
        logic       in_mode;
        logic [2:0] num_ch;
    } agrc_cfg_t;

    typedef struct packed {
        logic            req;
        agrc_xfer_kind_t kind;
        logic [2:0]      chan;
        agrc_cfg_t       cfg;
    } agrc_xfer_t;

    typedef struct packed {
        logic [AGRC_ADDR_W-1:0] addr;
        logic [AGRC_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } agrc_bus_t;

endpackage : agrc_pkg

// [agrc_conv_engine.sv]
`timescale 1ns/1ps

module agrc_conv_engine
    import agrc_pkg::*;
(
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    // requests and settings from the register file
    input  wire logic       i_rst_req,
    input  wire logic       i_conv_req,
    input  wire logic       i_seq_mode,
    input  wire logic       i_cfg_write,
    input  wire agrc_cfg_t  i_cfg,
    output logic            o_rst_ack,
    output logic            o_conv_ack,
    // converter side
    input  wire logic       i_xfer_done,
    output agrc_xfer_t      o_xfer,
    output logic            o_conv_reset,
    output logic            o_busy
);

    typedef enum logic [2:0] {
        ENG_IDLE,
        ENG_RST_PULSE,
        ENG_RST_WAIT,
        ENG_CFG,
        ENG_CONV
    } agrc_eng_st_t;

    typedef struct packed {
        agrc_eng_st_t           st;
        logic [AGRC_CNT_W-1:0]  cnt;
        logic [2:0]             last;
        logic                   cfg_pend;
        logic                   rst_pin;
        logic                   busy;
        agrc_xfer_t             xfer;
    } agrc_eng_t;

    agrc_eng_t eng_reg;
    agrc_eng_t eng_next;
    logic [2:0] last_chan;

    // differential mode ignores the top bit of the channel count
    assign last_chan = i_cfg.in_mode ? i_cfg.num_ch : {1'b0, i_cfg.num_ch[1:0]}; // RULE15

    assign o_rst_ack  = i_rst_req;                                        // RULE9
    assign o_conv_ack = i_conv_req & (i_seq_mode                          // RULE14
                        | (eng_reg.st == ENG_IDLE & ~eng_reg.cfg_pend & ~i_rst_req)); // RULE12

    always_comb
    begin
        eng_next = eng_reg;
        case (eng_reg.st)
            ENG_IDLE:
            begin
                if (eng_reg.cfg_pend)
                begin
                    eng_next.st       = ENG_CFG;
                    eng_next.cfg_pend = 1'b0;
                    eng_next.xfer     = '{req: 1'b1, kind: AGRC_XFER_CFG, chan: 3'h0, cfg: i_cfg};
                end
                else if (o_conv_ack & ~i_seq_mode)                        // RULE11
                begin
                    eng_next.st   = ENG_CONV;
                    eng_next.last = last_chan;
                    eng_next.xfer = '{req: 1'b1, kind: AGRC_XFER_CONV, chan: 3'h0,
                                      cfg: i_cfg};                                  // RULE16
                end
            end
            ENG_RST_PULSE:
            begin
                eng_next.cnt = eng_reg.cnt - 1'b1;
                if (eng_reg.cnt == '0)
                begin
                    eng_next.rst_pin = 1'b0;
                    eng_next.st      = ENG_RST_WAIT;
                    eng_next.cnt     = AGRC_RST_WAIT_CYC - 1'b1;
                end
            end
            ENG_RST_WAIT:
            begin
                eng_next.cnt = eng_reg.cnt - 1'b1;
                if (eng_reg.cnt == '0)
                begin
                    // auto-configuration with the current register contents
                    eng_next.st   = ENG_CFG;                                   // RULE8
                    eng_next.xfer = '{req: 1'b1, kind: AGRC_XFER_CFG, chan: 3'h0,
                                      cfg: i_cfg};                                  // RULE19
                end
            end
            ENG_CFG:
            begin
                if (i_xfer_done)
                begin
                    eng_next.st       = ENG_IDLE;
                    eng_next.xfer.req = 1'b0;
                end
            end
            ENG_CONV:
            begin
                if (i_xfer_done)
                begin
                    if (eng_reg.xfer.chan == eng_reg.last)
                    begin
                        eng_next.st       = ENG_IDLE;
                        eng_next.xfer.req = 1'b0;
                    end
                    else
                    begin
                        eng_next.xfer.chan = eng_reg.xfer.chan + 1'b1;        // RULE16
                    end
                end
            end
            default:
            begin
                eng_next.st = ENG_IDLE;
            end
        endcase
        if (i_cfg_write)
        begin
            eng_next.cfg_pend = 1'b1;
        end
        // reset aborts whatever is running; its auto-config covers a pending one
        if (i_rst_req)
        begin
            eng_next.st       = ENG_RST_PULSE;
            eng_next.cnt      = AGRC_RST_PULSE_CYC - 1'b1;
            eng_next.rst_pin  = 1'b1;                                     // RULE7
            eng_next.cfg_pend = 1'b0;
            eng_next.xfer.req = 1'b0;
        end
        eng_next.busy = (eng_next.st != ENG_IDLE) | eng_next.cfg_pend;   // RULE10
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            eng_reg <= '{st: ENG_IDLE, xfer: '{kind: AGRC_XFER_CFG, default: '0}, default: '0};
        end
        else
        begin
            eng_reg <= eng_next;
        end
    end

    assign o_xfer       = eng_reg.xfer;
    assign o_conv_reset = eng_reg.rst_pin;
    assign o_busy       = eng_reg.busy;                                   // RULE18

endmodule : agrc_conv_engine

// [agrc_ctrl.sv]
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: reserved bits read back as zero here; software must not rely on it.
// RULE2: software writes zero to reserved bits; writes there are ignored.
// RULE3: status flags are set by hardware only, cleared by a written one; here busy is cleared by hardware and status writes are ignored.
// RULE4: request bits are set by a written one, cleared only by hardware.
// RULE5: reset requests sit at bits 16 to 19, converter 1 lowest.
// RULE6: conversion requests sit at bits 0 to 3, converter 1 lowest.
// RULE7: a reset request drives the matching converter's reset pin.
// RULE8: after the reset phase the converter is configured automatically.
// RULE9: reset request bits clear themselves once taken.
// RULE10: busy covers reset pulse plus auto-configuration, drops when both finish.
// RULE11: manual mode: a written one starts one conversion event.
// RULE12: conversion request bit clears itself once accepted.
// RULE13: software should see busy clear before requesting a conversion.
// RULE14: sequencer mode: conversion request does nothing and clears at once.
// RULE15: an event converts exactly the configured number of active channels.
// RULE16: channels convert from channel 0 upward.
// RULE17: two-converter build leaves converters 3 and 4 unimplemented.
// RULE18: status busy bits 0 to 3 show sampling, transfer, reset or config.
// RULE19: auto-configuration sends the current configuration register contents.
// RULE20: writing zero to a request bit changes nothing.
module agrc_ctrl
    import agrc_pkg::*;
#(
    parameter int unsigned NUM_CONV = AGRC_MAX_CONV
)
(
    // clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_b,
    // register port
    input  wire logic [AGRC_ADDR_W-1:0]      i_addr,
    input  wire logic [AGRC_DATA_W-1:0]      i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [AGRC_DATA_W-1:0]      o_rdata,
    // converter side
    input  wire logic [AGRC_MAX_CONV-1:0]    i_xfer_done,
    output agrc_xfer_t [AGRC_MAX_CONV-1:0]   o_xfer,
    output logic      [AGRC_MAX_CONV-1:0]    o_conv_reset
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [AGRC_MAX_CONV-1:0]            rst_req;
        logic [AGRC_MAX_CONV-1:0]            conv_req;
        logic [AGRC_MAX_CONV-1:0]            seq_mode;
        agrc_cfg_t [AGRC_MAX_CONV-1:0]       cfg;
        logic [AGRC_MAX_CONV-1:0]            cfg_wr;
        logic [AGRC_DATA_W-1:0]              rdata;
    } agrc_ctrl_t;

    agrc_ctrl_t ctl_reg;
    agrc_ctrl_t ctl_next;

    agrc_bus_t                 bus;
    logic [AGRC_MAX_CONV-1:0]  rst_ack;
    logic [AGRC_MAX_CONV-1:0]  conv_ack;
    logic [AGRC_MAX_CONV-1:0]  busy;
    logic [AGRC_MAX_CONV-1:0]  impl_mask;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // ************************************************************
    // per-converter engines
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < AGRC_MAX_CONV; g++)
        begin : g_conv
            if (g < NUM_CONV)
            begin : g_impl
                assign impl_mask[g] = 1'b1;
                agrc_conv_engine u_engine (
                    .i_sys_clk    (i_sys_clk),
                    .i_rst_b      (i_rst_b),
                    .i_rst_req    (ctl_reg.rst_req[g]),
                    .i_conv_req   (ctl_reg.conv_req[g]),
                    .i_seq_mode   (ctl_reg.seq_mode[g]),
                    .i_cfg_write  (ctl_reg.cfg_wr[g]),
                    .i_cfg        (ctl_reg.cfg[g]),
                    .o_rst_ack    (rst_ack[g]),
                    .o_conv_ack   (conv_ack[g]),
                    .i_xfer_done  (i_xfer_done[g]),
                    .o_xfer       (o_xfer[g]),
                    .o_conv_reset (o_conv_reset[g]),
                    .o_busy       (busy[g])
                );
            end
            else
            begin : g_absent
                // absent converters: request bits never set, outputs idle
                assign impl_mask[g]    = 1'b0;                            // RULE17
                assign rst_ack[g]      = 1'b0;
                assign conv_ack[g]     = 1'b0;
                assign busy[g]         = 1'b0;
                assign o_xfer[g]       = '{kind: AGRC_XFER_CFG, default: '0};
                assign o_conv_reset[g] = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // register file
    // ************************************************************
    always_comb
    begin
        logic wr_ctrl;
        wr_ctrl  = bus.wr & (bus.addr == AGRC_OFF_CTRL);
        ctl_next = ctl_reg;
        ctl_next.cfg_wr = '0;
        ctl_next.rdata  = '0;

        // a new one written in the clearing cycle wins over the clear
        ctl_next.rst_req  = (ctl_reg.rst_req & ~rst_ack)                  // RULE9
                          | ({AGRC_MAX_CONV{wr_ctrl}}                     // RULE4
                          & bus.wdata[AGRC_RST_REQ_LSB +: AGRC_MAX_CONV]  // RULE5
                          & impl_mask);                                   // RULE20
        ctl_next.conv_req = (ctl_reg.conv_req & ~conv_ack)                // RULE12
                          | ({AGRC_MAX_CONV{wr_ctrl}}                     // RULE4
                          & bus.wdata[AGRC_CONV_REQ_LSB +: AGRC_MAX_CONV] // RULE6
                          & impl_mask);                                   // RULE20

        if (bus.wr & (bus.addr == AGRC_OFF_MODE))
        begin
            ctl_next.seq_mode = bus.wdata[AGRC_SEQ_MODE_LSB +: AGRC_MAX_CONV] & impl_mask;
        end
        for (int i = 0; i < AGRC_MAX_CONV; i++)
        begin
            if (bus.wr & (bus.addr == AGRC_OFF_CFG[i]) & impl_mask[i])
            begin
                ctl_next.cfg[i].in_mode = bus.wdata[AGRC_CFG_MODE_BIT];
                ctl_next.cfg[i].num_ch  = bus.wdata[AGRC_CFG_NUM_LSB +: 3];
                ctl_next.cfg_wr[i]      = 1'b1;
            end
        end

        // reserved and unmapped bits answer zero
        if (bus.rd)
        begin
            if (bus.addr == AGRC_OFF_CTRL)
            begin
                ctl_next.rdata[AGRC_RST_REQ_LSB +: AGRC_MAX_CONV]  = ctl_reg.rst_req;  // RULE1
                ctl_next.rdata[AGRC_CONV_REQ_LSB +: AGRC_MAX_CONV] = ctl_reg.conv_req;
            end
            else if (bus.addr == AGRC_OFF_STATUS)
            begin
                ctl_next.rdata[AGRC_BUSY_LSB +: AGRC_MAX_CONV] = busy;   // RULE18 RULE3
            end
            else if (bus.addr == AGRC_OFF_MODE)
            begin
                ctl_next.rdata[AGRC_SEQ_MODE_LSB +: AGRC_MAX_CONV] = ctl_reg.seq_mode;
            end
            else
            begin
                for (int i = 0; i < AGRC_MAX_CONV; i++)
                begin
                    if ((bus.addr == AGRC_OFF_CFG[i]) & impl_mask[i])
                    begin
                        ctl_next.rdata[AGRC_CFG_MODE_BIT]    = ctl_reg.cfg[i].in_mode;
                        ctl_next.rdata[AGRC_CFG_NUM_LSB +: 3] = ctl_reg.cfg[i].num_ch;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctl_reg <= '{rst_req:  AGRC_CTRL_RST[AGRC_RST_REQ_LSB +: AGRC_MAX_CONV],
                         conv_req: AGRC_CTRL_RST[AGRC_CONV_REQ_LSB +: AGRC_MAX_CONV],
                         seq_mode: AGRC_SEQ_MODE_RST,
                         cfg:      {AGRC_MAX_CONV{AGRC_IN_MODE_RST, AGRC_NUM_CH_RST}},
                         cfg_wr:   '0,
                         rdata:    '0};
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    assign o_rdata = ctl_reg.rdata;

endmodule : agrc_ctrl

// [agrc_checker.sv]
`timescale 1ns/1ps

module agrc_checker
    import agrc_pkg::*;
#(
    parameter int unsigned NUM_CONV = AGRC_MAX_CONV
)
(
    // clock and reset
    input wire logic                      i_sys_clk,
    input wire logic                      i_rst_b,
    // register port
    input wire logic [AGRC_ADDR_W-1:0]    i_addr,
    input wire logic [AGRC_DATA_W-1:0]    i_wdata,
    input wire logic                      i_wr,
    input wire logic                      i_rd,
    input wire logic [AGRC_DATA_W-1:0]    o_rdata,
    // converter side
    input wire logic [AGRC_MAX_CONV-1:0]  i_xfer_done,
    input wire agrc_xfer_t [AGRC_MAX_CONV-1:0] o_xfer,
    input wire logic [AGRC_MAX_CONV-1:0]  o_conv_reset
);
    // ************************************************************
    // converter 1 only: the others share the same engine
    // ************************************************************
    logic [2:0] last_ch;
    logic       conv_on;
    assign last_ch = o_xfer[0].cfg.in_mode ? o_xfer[0].cfg.num_ch
                                           : {1'b0, o_xfer[0].cfg.num_ch[1:0]};
    assign conv_on = o_xfer[0].req && o_xfer[0].kind == AGRC_XFER_CONV;

    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    a_reset_pin_rise: assert property (i_wr && i_addr == AGRC_OFF_CTRL && i_wdata[16]
        |-> ##2 o_conv_reset[0]) else $error("reset pin not raised");
    a_reset_pulse_len: assert property ($rose(o_conv_reset[0])
        |-> ##24 o_conv_reset[0] ##1 !o_conv_reset[0]) else $error("reset pulse length wrong");
    a_auto_config: assert property ($fell(o_conv_reset[0])
        |-> ##[1:300] (o_xfer[0].req && o_xfer[0].kind == AGRC_XFER_CFG))
        else $error("no configuration after reset");
    a_quiet_in_reset: assert property (o_conv_reset[0] |-> !o_xfer[0].req)
        else $error("transfer during reset pulse");
    a_first_channel: assert property ($rose(conv_on) |-> o_xfer[0].chan == 3'h0)
        else $error("event not started at channel 0");
    a_chan_step: assert property (conv_on && i_xfer_done[0] && o_xfer[0].chan != last_ch
        |=> conv_on && o_xfer[0].chan == $past(o_xfer[0].chan) + 3'h1)
        else $error("channel not advanced by one");
    a_event_end: assert property (conv_on && i_xfer_done[0] && o_xfer[0].chan == last_ch
        |=> !o_xfer[0].req) else $error("event not ended at last channel");
    a_req_held: assert property (o_xfer[0].req && !i_xfer_done[0]
        && !i_wr && !$past(i_wr) |=> o_xfer[0].req && $stable(o_xfer[0].chan))
        else $error("transfer dropped early");
endmodule : agrc_checker

bind agrc_ctrl agrc_checker #(.NUM_CONV(NUM_CONV)) u_chk (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_xfer_done(i_xfer_done), .o_xfer(o_xfer),
    .o_conv_reset(o_conv_reset));

// [agrc_conv_model.sv]
`timescale 1ns/1ps

module agrc_conv_model
    import agrc_pkg::*;
(
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_b,
    // block side
    input  wire agrc_xfer_t [3:0]     i_xfer,
    input  wire logic [3:0]           i_conv_reset,
    input  wire logic                 i_slow,
    output logic [3:0]                o_xfer_done
);
    // ************************************************************
    // serial transfer timing
    // ************************************************************
    logic [3:0][3:0] cnt;

    // answers only to a live request, never while held in reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt         <= '0;
            o_xfer_done <= '0;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (!i_xfer[k].req || i_conv_reset[k] || o_xfer_done[k])
                begin
                    cnt[k]         <= 4'h0;
                    o_xfer_done[k] <= 1'b0;
                end
                else if (cnt[k] >= (i_slow ? 4'h9 : 4'h1))
                begin
                    cnt[k]         <= 4'h0;
                    o_xfer_done[k] <= 1'b1;
                end
                else
                begin
                    cnt[k] <= cnt[k] + 4'h1;
                end
            end
        end
    end
endmodule : agrc_conv_model

// [adc_global_request_control_bench.sv]
`timescale 1ns/1ps

module adc_global_request_control_bench
    import agrc_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic             i_sys_clk = 1'b0;
    logic             i_rst_b   = 1'b0;
    logic [11:0]      i_addr    = 12'h000;
    logic [31:0]      i_wdata   = 32'h0000_0000;
    logic             i_wr      = 1'b0;
    logic             i_rd      = 1'b0;
    logic             slow      = 1'b0;
    logic             rd_seen   = 1'b0;
    logic [31:0]      o_rdata;
    logic [3:0]       done;
    logic [3:0]       o_conv_reset;
    logic [3:0]       rst2;
    agrc_xfer_t [3:0] o_xfer;
    logic [31:0]      rnd = 32'h0000_9be2;
    logic [31:0]      we;
    logic [31:0]      wm;
    logic [10:0]      wx;
    logic [31:0]      exp_q[$];
    logic [31:0]      msk_q[$];
    logic [10:0]      xq[$];
    agrc_cfg_t        cur_cfg[4];
    int               fails = 0;
    int               samples_checked = 0;

    always #2 i_sys_clk = ~i_sys_clk;

    agrc_ctrl #(.NUM_CONV(4)) uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_xfer_done(done),
        .o_xfer(o_xfer), .o_conv_reset(o_conv_reset));
    agrc_conv_model u_conv (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_xfer(o_xfer),
        .i_conv_reset(o_conv_reset), .i_slow(slow), .o_xfer_done(done));
    // reduced build runs in lockstep with uut on converters 1 and 2
    agrc_ctrl #(.NUM_CONV(2)) uut_reduced (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(),
        .i_xfer_done(done), .o_xfer(), .o_conv_reset(rst2));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [10:0] ent(input int k, input agrc_xfer_kind_t t,
                                        input logic [2:0] ch, input agrc_cfg_t c);
        return {2'(k), 1'b1, t, ch, c};
    endfunction : ent

    task automatic final_report;
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                      output logic [31:0] d);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask : rd

    task automatic wait_idle(input int k);
        logic [31:0] d;
        int          n;
        d = 32'hFFFF_FFFF;
        n = 0;
        repeat (3) @(posedge i_sys_clk);
        while (d[k] !== 1'b0 && n < 2000)
        begin
            rd(AGRC_OFF_STATUS, 32'h0, 32'h0, d);
            n++;
        end
        check("busy clear", 32'h0, {31'h0, d[k]});
    endtask : wait_idle

    // ************************************************************
    // result watcher
    // ************************************************************
    always @(posedge i_sys_clk) rd_seen <= i_rd;

    always @(negedge i_sys_clk)
    begin
        if (rd_seen)
        begin
            we = exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF;
            wm = msk_q.size() > 0 ? msk_q.pop_front() : 32'hFFFF_FFFF;
            check("read data", we & wm, o_rdata & wm);
        end
        for (int k = 0; k < 4; k++)
        begin
            if (done[k] && o_xfer[k].req)
            begin
                wx = {2'(k), o_xfer[k]};
                // chan carries no meaning in a configuration transfer
                if (o_xfer[k].kind == AGRC_XFER_CFG)
                    wx[6:4] = 3'h0;
                check("transfer", 32'(xq.size() > 0 ? xq.pop_front() : 11'h7FF),
                      32'(wx));
            end
        end
    end

    initial
    begin
        repeat (50000) @(posedge i_sys_clk);
        fails++;
        final_report();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        int          k;
        agrc_cfg_t   c;
        logic [2:0]  last;
        logic [31:0] junk;
        for (k = 0; k < 4; k++)
            cur_cfg[k] = {AGRC_IN_MODE_RST, AGRC_NUM_CH_RST};
        repeat (10) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        rd(AGRC_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, junk);
        rd(AGRC_OFF_STATUS, 32'h0, 32'hF, junk);
        rd(12'h00C, 32'h0, 32'hFFFF_FFFF, junk);
        rd(AGRC_OFF_CFG[1], 32'h0F00_0000, 32'h0F00_0000, junk);
        for (k = 0; k < 4; k++)
        begin
            slow <= k[0];
            xq.push_back(ent(k, AGRC_XFER_CFG, 3'h0, cur_cfg[k]));
            wr(AGRC_OFF_CTRL, 32'h1 << (16 + k));
            repeat (2) @(posedge i_sys_clk);
            #1 check("reset pin", 32'h1 << k, {28'h0, o_conv_reset});
            check("reduced reset pin", 32'(o_conv_reset & 4'h3), 32'(rst2));
            rd(AGRC_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, junk);
            repeat (40) @(posedge i_sys_clk);
            rd(AGRC_OFF_STATUS, 32'h1 << k, 32'hF, junk);
            wait_idle(k);
        end
        for (int it = 0; it < 8; it++)
        begin
            rnd = xs(rnd);
            k = it % 4;
            c = rnd[3:0];
            slow <= rnd[4];
            cur_cfg[k] = c;
            xq.push_back(ent(k, AGRC_XFER_CFG, 3'h0, c));
            wr(AGRC_OFF_CFG[k], {4'h0, c, 24'h0});
            rd(AGRC_OFF_CFG[k], {4'h0, c, 24'h0}, 32'h0F00_0000, junk);
            wait_idle(k);
            last = c.in_mode ? c.num_ch : {1'b0, c.num_ch[1:0]};
            for (int ch = 0; ch <= int'(last); ch++)
                xq.push_back(ent(k, AGRC_XFER_CONV, 3'(ch), c));
            wr(AGRC_OFF_CTRL, 32'h1 << k);
            wait_idle(k);
            rd(AGRC_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, junk);
        end
        wr(AGRC_OFF_MODE, 32'h2);
        rd(AGRC_OFF_MODE, 32'h2, 32'hF, junk);
        wr(AGRC_OFF_CTRL, 32'h2);
        rd(AGRC_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, junk);
        rd(AGRC_OFF_STATUS, 32'h0, 32'hF, junk);
        wr(AGRC_OFF_STATUS, 32'hF);
        rd(AGRC_OFF_STATUS, 32'h0, 32'hF, junk);
        wr(AGRC_OFF_MODE, 32'h0);
        repeat (20) @(posedge i_sys_clk);
        check("open transfers", 32'h0, 32'(xq.size()));
        final_report();
    end
endmodule : adc_global_request_control_bench
